// ===== logic/jri_sync.sv
`timescale 1ns/1ps

// two-stage synchroniser; each bit is independent, so multi-bit use is
// only safe for static levels or for one toggle bit per event
module jri_sync #(
	parameter int W = 1
) (
	// destination domain
	input  wire logic         clk_i,
	input  wire logic         rst_n_i,
	// source level
	input  wire logic [W-1:0] d_i,
	// synchronised level
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			meta_q <= '0;
			sync_q <= '0;
		end
		else
		begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;

endmodule

// ===== logic/jri_top.sv
// Functional notes
// (RULE_01) shift register as wide as RAM data
// (RULE_02) serial data shifted on data-register clock
// (RULE_03) shift only while shift enable high
// (RULE_04) full word goes parallel to write data
// (RULE_05) pipeline register aligns data with address
// (RULE_06) counter addresses; optional address load opcode
// (RULE_07) writes and counting only on opcode match
// (RULE_08) partner raises update strobe in Update-DR
// (RULE_09) update strobe rise loads data and address
// (RULE_10) write clock is inverted update strobe
// (RULE_11) non-inverted write clock for falling-edge RAM
// (RULE_12) write outputs aligned to write clock
// (RULE_13) ring counter steps after each block range
// (RULE_14) broadcast mode writes all blocks together
// (RULE_15) per-block opcode selects single target block
// (RULE_16) driver loads instruction before shifting data
// (RULE_17) jtag reset presets counter to top address
`timescale 1ns/1ps

package jri_pkg;

	localparam int DATA_W = 4;
	localparam int ADDR_W = 2;
	localparam int BLK_N  = 4;
	localparam int IR_W   = 8;

	localparam logic [IR_W-1:0] OP_START    = 8'h22;
	localparam logic [IR_W-1:0] OP_ADDR     = 8'h24;
	localparam logic [IR_W-1:0] OP_BLK_BASE = 8'h30;

	localparam logic [ADDR_W-1:0] ADDR_MAX   = 2'h3;
	localparam logic [ADDR_W-1:0] ADDR_ONE   = 2'h1;
	localparam logic [ADDR_W-1:0] ADDR_RST   = ADDR_MAX;
	localparam logic [BLK_N-1:0]  RING_RST   = 4'h1;
	localparam logic [BLK_N-1:0]  WEN_NONE   = 4'h0;
	localparam logic [BLK_N-1:0]  WEN_ALL    = 4'hf;
	localparam logic [DATA_W-1:0] DATA_RST   = 4'h0;
	localparam logic              WCLK_RST   = 1'b1;

	// bit positions in the config word crossed into the link domain
	localparam int CFG_MODE_LSB = 0;
	localparam int CFG_NOINV    = 2;
	localparam int CFG_W        = 3;
	// bit positions in the status word crossed into the system domain
	localparam int ST_ACTIVE    = 0;
	localparam int ST_DONE      = 1;
	localparam int ST_W         = 2;

	typedef enum logic [1:0] {
		JRI_SEL_RING   = 2'b00,
		JRI_SEL_BCAST  = 2'b01,
		JRI_SEL_OPCODE = 2'b10
	} jri_sel_mode_t;

	typedef struct packed {
		logic [BLK_N-1:0]  wen;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
	} jri_ram_wr_t;

	typedef struct packed {
		logic [DATA_W-1:0] shift;
		logic [ADDR_W-1:0] addr_shift;
		logic              upd;
		logic              wrote;
		logic [BLK_N-1:0]  ring;
		jri_ram_wr_t       ram;
		logic              wclk;
		logic              active;
		logic              done_tgl;
	} jri_link_state_t;

	typedef struct packed {
		logic done_prev;
		logic init_active;
		logic word_done;
	} jri_sys_state_t;

	// one-hot of the block addressed by a per-block opcode, zero if none
	function automatic logic [BLK_N-1:0] blk_hit(input logic [IR_W-1:0] ir);
		logic [BLK_N-1:0] hit;
		hit = '0;
		for (int i = 0; i < BLK_N; i++)
		begin
			if (ir == OP_BLK_BASE + IR_W'(i))
				hit[i] = 1'b1;
		end
		return hit;
	endfunction

	function automatic logic [BLK_N-1:0] ring_step(input logic [BLK_N-1:0] r);
		return {r[BLK_N-2:0], r[BLK_N-1]};
	endfunction

endpackage

module jri_top (
	// system domain
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_n_i,
	// user jtag access macro, link domain
	input  wire logic                      user_dr_clock_i,
	input  wire logic                      user_jtag_reset_n_i,
	input  wire logic [jri_pkg::IR_W-1:0]  user_instruction_value_i,
	input  wire logic                      user_serial_data_in_i,
	input  wire logic                      user_dr_shift_enable_i,
	input  wire logic                      user_dr_update_strobe_i,
	// configuration, system domain, static while loading
	input  wire logic [1:0]                sel_mode_i,
	input  wire logic                      wclk_no_invert_i,
	// ram write port, link domain
	output jri_pkg::jri_ram_wr_t           ram_wr_o,
	output logic                           ram_wclk_o,
	// status, system domain
	output logic                           init_active_o,
	output logic                           word_done_o
);

	jri_pkg::jri_link_state_t lq;
	jri_pkg::jri_link_state_t ld;
	jri_pkg::jri_sys_state_t  sq;
	jri_pkg::jri_sys_state_t  sd;

	logic [jri_pkg::CFG_W-1:0] cfg_raw;
	logic [jri_pkg::CFG_W-1:0] cfg_sync;
	logic [jri_pkg::ST_W-1:0]  st_raw;
	logic [jri_pkg::ST_W-1:0]  st_sync;

	jri_pkg::jri_sel_mode_t    mode;
	logic                      no_inv;
	logic                      is_start;
	logic                      is_addr;
	logic [jri_pkg::BLK_N-1:0] hit;
	logic                      en;
	logic                      upd_rise;

	// config is quasi-static, so a plain per-bit level crossing is enough
	assign cfg_raw = {wclk_no_invert_i, sel_mode_i};

	jri_sync #(
		.W (jri_pkg::CFG_W)
	) u_cfg_sync (
		.clk_i   (user_dr_clock_i),
		.rst_n_i (user_jtag_reset_n_i),
		.d_i     (cfg_raw),
		.q_o     (cfg_sync)
	);

	assign mode     = jri_pkg::jri_sel_mode_t'(
		cfg_sync[jri_pkg::CFG_MODE_LSB +: 2]);
	assign no_inv   = cfg_sync[jri_pkg::CFG_NOINV];
	assign is_start = (user_instruction_value_i == jri_pkg::OP_START);
	assign is_addr  = (user_instruction_value_i == jri_pkg::OP_ADDR);
	assign hit      = jri_pkg::blk_hit(user_instruction_value_i);
	// the strobe is sampled on the dr clock, which runs through Update-DR
	assign upd_rise = user_dr_update_strobe_i & ~lq.upd;

	always_comb
	begin
		ld     = lq;
		ld.upd = user_dr_update_strobe_i;

		unique case (mode)
			jri_pkg::JRI_SEL_OPCODE:
				en = |hit; // see (RULE_15)
			jri_pkg::JRI_SEL_RING,
			jri_pkg::JRI_SEL_BCAST:
				en = is_start; // see (RULE_07)
			default:
				en = is_start;
		endcase
		ld.active = en;

		// address opcode steers serial data into its own register
		if (user_dr_shift_enable_i) // see (RULE_03)
		begin
			if (is_addr)
				ld.addr_shift = {user_serial_data_in_i, // see (RULE_06)
					lq.addr_shift[jri_pkg::ADDR_W-1:1]};
			else
				ld.shift = {user_serial_data_in_i, // see (RULE_02)
					lq.shift[jri_pkg::DATA_W-1:1]}; // see (RULE_01)
		end

		// falling-edge RAMs take the strobe as is
		if (no_inv)
			ld.wclk = user_dr_update_strobe_i; // see (RULE_11)
		else
			ld.wclk = ~user_dr_update_strobe_i; // see (RULE_10)

		if (upd_rise && is_addr)
		begin
			// preload one below so the next write hits the loaded address
			ld.ram.addr = lq.addr_shift - jri_pkg::ADDR_ONE; // see (RULE_06)
			ld.wrote    = 1'b0;
		end
		else if (upd_rise && en)
		begin
			ld.ram.data = lq.shift; // see (RULE_04) (RULE_05) (RULE_09)
			ld.ram.addr = lq.ram.addr + jri_pkg::ADDR_ONE; // see (RULE_09)
			ld.wrote    = 1'b1;
			if (lq.wrote && lq.ram.addr == jri_pkg::ADDR_MAX)
				ld.ring = jri_pkg::ring_step(lq.ring); // see (RULE_13)
			unique case (mode)
				jri_pkg::JRI_SEL_BCAST:
					ld.ram.wen = jri_pkg::WEN_ALL; // see (RULE_14)
				jri_pkg::JRI_SEL_OPCODE:
					ld.ram.wen = hit; // see (RULE_15)
				jri_pkg::JRI_SEL_RING:
					ld.ram.wen = ld.ring; // see (RULE_13)
				default:
					ld.ram.wen = ld.ring;
			endcase
			ld.done_tgl = ~lq.done_tgl;
		end

		// enables drop as soon as the instruction no longer matches
		if (!en)
			ld.ram.wen = jri_pkg::WEN_NONE; // see (RULE_07)
	end

	// all ram outputs but the enable drop on a mismatch move on one edge with wclk, one dr clock before an inverted wclk rises
	always_ff @(posedge user_dr_clock_i or negedge user_jtag_reset_n_i)
	begin
		if (!user_jtag_reset_n_i)
		begin
			lq            <= '0;
			lq.ram.addr   <= jri_pkg::ADDR_RST; // see (RULE_17)
			lq.ram.data   <= jri_pkg::DATA_RST;
			lq.ram.wen    <= jri_pkg::WEN_NONE;
			lq.ring       <= jri_pkg::RING_RST;
			lq.wclk       <= jri_pkg::WCLK_RST;
		end
		else
		begin
			lq <= ld; // see (RULE_12)
		end
	end

	assign ram_wr_o   = lq.ram;
	assign ram_wclk_o = lq.wclk;

	// one toggle per written word, so no event is lost across domains
	assign st_raw = {lq.done_tgl, lq.active};

	jri_sync #(
		.W (jri_pkg::ST_W)
	) u_st_sync (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (st_raw),
		.q_o     (st_sync)
	);

	always_comb
	begin
		sd             = sq;
		sd.done_prev   = st_sync[jri_pkg::ST_DONE];
		sd.word_done   = st_sync[jri_pkg::ST_DONE] ^ sq.done_prev;
		sd.init_active = st_sync[jri_pkg::ST_ACTIVE];
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			sq <= '0;
		else
			sq <= sd;
	end

	assign init_active_o = sq.init_active;
	assign word_done_o   = sq.word_done;

endmodule

// ===== sim/jri_chk.sv
`timescale 1ns/1ps

module jri_chk (
	// system domain
	input logic                     sys_clk_i,
	input logic                     rst_n_i,
	// link domain, plus the system-domain configuration
	input logic                     user_dr_clock_i,
	input logic                     user_jtag_reset_n_i,
	input logic [jri_pkg::IR_W-1:0] user_instruction_value_i,
	input logic                     user_dr_update_strobe_i,
	input logic [1:0]               sel_mode_i,
	input logic                     wclk_no_invert_i,
	// outputs
	input jri_pkg::jri_ram_wr_t     ram_wr_o,
	input logic                     ram_wclk_o,
	input logic                     word_done_o
);
	wire       k  = user_dr_clock_i;
	wire       r  = user_jtag_reset_n_i;
	wire       s  = user_dr_update_strobe_i;
	wire [7:0] ir = user_instruction_value_i;
	wire [1:0] bi = ir[1:0];
	wire       pb = ir[7:2] == 6'h0c;
	wire       st = ir == jri_pkg::OP_START;
	wire       nm = !st && !pb;
	sequence upd_s;
		s && !$past(s);
	endsequence
	sequence wr_s;
		upd_s ##0 st;
	endsequence
	// the mode pin reaches the link logic two dr edges late, hence [*3]
	a_wclk_low: assert property (@(posedge k) disable iff (!r)
		!wclk_no_invert_i [*3] ##0 upd_s |=> !ram_wclk_o)
		else $error("wclk high");
	a_wclk_high: assert property (@(posedge k) disable iff (!r)
		!wclk_no_invert_i [*3] ##0 !s |=> ram_wclk_o)
		else $error("wclk low");
	a_wclk_same: assert property (@(posedge k) disable iff (!r)
		wclk_no_invert_i [*3] |=> ram_wclk_o == $past(s))
		else $error("wclk not strobe");
	a_word_hold: assert property (@(posedge k) disable iff (!r)
		!s || $past(s) |=> $stable(ram_wr_o.data)) else $error("data moved");
	a_addr_step: assert property (@(posedge k) disable iff (!r)
		wr_s |=> ram_wr_o.addr == $past(ram_wr_o.addr) + 2'h1)
		else $error("addr step");
	a_no_match: assert property (@(posedge k) disable iff (!r)
		nm ##1 nm |=> ram_wr_o.wen == jri_pkg::WEN_NONE) else $error("wen set");
	a_bcast_all: assert property (@(posedge k) disable iff (!r)
		wr_s ##0 sel_mode_i == 2'h1 |=> ram_wr_o.wen == jri_pkg::WEN_ALL)
		else $error("bcast wen");
	a_ring_one: assert property (@(posedge k) disable iff (!r)
		wr_s ##0 sel_mode_i == 2'h0 |=> $onehot(ram_wr_o.wen))
		else $error("ring wen");
	a_blk_pick: assert property (@(posedge k) disable iff (!r)
		upd_s ##0 pb ##0 sel_mode_i == 2'h2 |=> ram_wr_o.wen == 4'h1 << $past(bi))
		else $error("block wen");
	a_done_pulse: assert property (@(posedge sys_clk_i)
		disable iff (!rst_n_i) word_done_o |=> !word_done_o)
		else $error("done too long");
endmodule

// ===== sim/jri_macro.sv
`timescale 1ns/1ps

module jri_macro (
	// link clock
	input  wire logic clk_i,
	// access macro outputs
	output logic [7:0] ir_o,
	output logic       sd_o,
	output logic       sh_o,
	output logic       up_o
);
	initial
	begin
		ir_o = 8'h00;
		sd_o = 1'b0;
		sh_o = 1'b0;
		up_o = 1'b0;
	end

	// instruction first, then four bits lsb first, then one update
	task automatic word(input logic [7:0] op, input logic [3:0] w);
		@(posedge clk_i);
		ir_o <= op;
		for (int i = 0; i < 4; i++)
		begin
			@(posedge clk_i);
			sh_o <= 1'b1;
			sd_o <= w[i];
		end
		@(posedge clk_i);
		sh_o <= 1'b0;
		// released data line must not keep the last bit
		sd_o <= ~sd_o;
		up_o <= 1'b1;
		@(posedge clk_i);
		up_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// ===== sim/testbench.sv
`timescale 1ns/1ps

module testbench;
	logic                 sys_clk_i = 1'b0;
	logic                 dck       = 1'b0;
	logic                 rst_n     = 1'b0;
	logic                 jrst_n    = 1'b0;
	logic [1:0]           mode      = 2'h0;
	logic                 noinv     = 1'b0;
	logic [7:0]           ir;
	logic                 sd, sh, up, wclk, act, done;
	jri_pkg::jri_ram_wr_t wr;
	logic [1:0]           ea        = 2'h0;
	int                   bad_count = 0;
	int                   checked   = 0;
	int                   dones     = 0;

	always #50 sys_clk_i = ~sys_clk_i;
	always #40 dck = ~dck;
	always @(posedge sys_clk_i)
		if (done === 1'b1)
			dones++;

	jri_macro jri_macro_i (.clk_i(dck), .ir_o(ir), .sd_o(sd), .sh_o(sh),
		.up_o(up));
	jri_top jri_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n),
		.user_dr_clock_i(dck), .user_jtag_reset_n_i(jrst_n),
		.user_instruction_value_i(ir), .user_serial_data_in_i(sd),
		.user_dr_shift_enable_i(sh), .user_dr_update_strobe_i(up),
		.sel_mode_i(mode), .wclk_no_invert_i(noinv), .ram_wr_o(wr),
		.ram_wclk_o(wclk), .init_active_o(act), .word_done_o(done));

	task automatic complete_run;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [15:0] s, e);
		checked++;
		if (s !== e)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic put(input logic [7:0] op, input logic [3:0] w, ew);
		jri_macro_i.word(op, w);
		// the last dr edge launches wclk; look once it has settled
		@(negedge dck);
		chk("wen", 16'(wr.wen), 16'(ew));
		chk("wclk", 16'(wclk), 16'(!noinv));
		if (ew != 4'h0)
		begin
			chk("data", 16'(wr.data), 16'(w));
			chk("addr", 16'(wr.addr), 16'(ea));
			ea = ea + 2'h1;
		end
		else
			chk("addr", 16'(wr.addr), 16'(2'(ea - 2'h1)));
	endtask

	// the fifth word must leave block 0 and land in block 1
	task automatic t_ring;
		for (int i = 0; i < 5; i++)
			put(jri_pkg::OP_START, 4'(i * 5 + 3), 4'h1 << (i / 4));
		chk("active", 16'(act), 16'h1);
	endtask

	task automatic t_bcast;
		mode <= 2'h1;
		repeat (3) @(posedge sys_clk_i);
		put(jri_pkg::OP_START, 4'ha, 4'hf);
	endtask

	task automatic t_miss;
		put(8'h23, 4'h5, 4'h0);
		repeat (6) @(posedge sys_clk_i);
		chk("active", 16'(act), 16'h0);
	endtask

	task automatic t_blk;
		mode <= 2'h2;
		repeat (3) @(posedge sys_clk_i);
		for (int i = 0; i < 4; i++)
			put(jri_pkg::OP_BLK_BASE + 8'(i), 4'(9 - i), 4'h1 << i);
	endtask

	// only the last two shifted bits stay, so 4'hc loads address 3
	task automatic t_addr;
		ea = 2'h3;
		put(jri_pkg::OP_ADDR, 4'hc, 4'h0);
		put(jri_pkg::OP_BLK_BASE + 8'h2, 4'h5, 4'h4);
	endtask

	// follow mode: the idle write clock sits low like the strobe
	task automatic t_noinv;
		@(posedge sys_clk_i);
		noinv <= 1'b1;
		repeat (3) @(posedge sys_clk_i);
		put(jri_pkg::OP_BLK_BASE + 8'h3, 4'h6, 4'h8);
		@(posedge sys_clk_i);
		noinv <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
	endtask

	// mid-run link reset: counter back to the top, first write hits 0
	task automatic t_reset;
		@(posedge sys_clk_i);
		mode <= 2'h0;
		repeat (3) @(posedge sys_clk_i);
		jrst_n <= 1'b0;
		repeat (2) @(posedge sys_clk_i);
		chk("rst addr", 16'(wr.addr), 16'(jri_pkg::ADDR_MAX));
		chk("rst wen", 16'(wr.wen), 16'h0);
		chk("rst wclk", 16'(wclk), 16'h1);
		jrst_n <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		ea = 2'h0;
		put(jri_pkg::OP_START, 4'h9, 4'h1);
	endtask

	initial
	begin
		repeat (10) @(posedge sys_clk_i);
		rst_n <= 1'b1;
		jrst_n <= 1'b1;
		repeat (4) @(posedge sys_clk_i);
		t_ring();
		t_bcast();
		t_miss();
		t_blk();
		t_addr();
		t_noinv();
		t_reset();
		repeat (6) @(posedge sys_clk_i);
		chk("done count", 16'(dones), 16'hd);
		complete_run();
	end

	initial
	begin
		repeat (2000) @(posedge sys_clk_i);
		bad_count++;
		complete_run();
	end
endmodule

bind jri_top jri_chk jri_chk_i (.sys_clk_i, .rst_n_i, .user_dr_clock_i,
	.user_jtag_reset_n_i, .user_instruction_value_i, .user_dr_update_strobe_i,
	.sel_mode_i, .wclk_no_invert_i, .ram_wr_o, .ram_wclk_o, .word_done_o);
